// ### include/dri_pkg.sv
// Constants for the DRAM reset and initialization tracker.
// Assumes a 50 MHz system clock and a link clock from the controller.
`default_nettype none
package dri_pkg;
    localparam int unsigned SYS_CLK_MHZ = 50;
    localparam int unsigned BANK_GROUPS = 2;
    localparam int unsigned BANKS_PER_GROUP = 4;
    localparam int unsigned BURST_LEN_FULL = 8;
    localparam int unsigned BURST_LEN_CHOP = 4;
    localparam int unsigned ROW_BITS = 15;
    localparam int unsigned COL_BITS = 10;
    localparam int unsigned AP_BIT = 10;
    localparam int unsigned BC_BIT = 12;
    localparam int unsigned MR_SEL_LSB = 14;
    localparam int unsigned GD_BIT = 3;
    localparam logic [2:0] MR_GEARDOWN = 3'h3;
    localparam int unsigned INIT_WAIT_US = 500;
    localparam int unsigned INIT_WAIT_CYC = INIT_WAIT_US * SYS_CLK_MHZ;
    localparam int unsigned CNT_W = 16;
    // Mode register defaults after reset (gear-down half rate etc)
    localparam logic GEARDOWN_RST = 1'b0;
    localparam logic PDA_RST = 1'b0;
    localparam logic MPS_RST = 1'b0;
    localparam logic [2:0] CAL_RST = 3'h0;
    localparam logic [2:0] PARL_RST = 3'h0;
    // Command codes on the link: cs_n, act_n, ras, cas, we
    localparam logic [4:0] CMD_DES = 5'h10;
    localparam logic [4:0] CMD_MRS = 5'h08;
    localparam logic [4:0] CMD_ZQCL = 5'h0e;
    localparam logic [4:0] CMD_RD = 5'h0b;
    localparam logic [4:0] CMD_WR = 5'h0a;
    localparam logic [2:0] MR_ORDER_LAST = 3'h0;
    typedef enum logic [2:0] {
        ST_RESET = 3'b000,
        ST_INTERNAL = 3'b001,
        ST_WAIT_CKE = 3'b010,
        ST_MODE_LOAD = 3'b011,
        ST_CAL = 3'b100,
        ST_READY = 3'b101
    } dri_state_t;
endpackage
`default_nettype wire

// ### rtl/dri_init.sv
// DRAM-side tracker of reset, power-up initialization and access decode.
// Assumes the controller keeps its timing; the link clock may stop.
`default_nettype none
module dri_init (
    input wire logic i_clk_sys, // System clock, 50 MHz
    input wire logic i_resetn, // Sync reset, active low
    input wire logic i_clk_link, // Controller clock CK
    input wire logic i_dram_reset_n, // Pin reset, active low
    input wire logic i_cke, // Clock enable pin
    input wire logic i_odt, // Termination request pin
    input wire logic [4:0] i_cmd, // cs_n, act_n, ras, cas, we
    input wire logic [1:0] i_bg, // Bank group
    input wire logic [1:0] i_ba, // Bank
    input wire logic [16:0] i_addr, // Address A0-A16
    input wire logic i_cal_done, // DLL lock and ZQ init elapsed
    output logic o_odt_active, // Termination enabled
    output logic o_ready, // Normal operation allowed
    output logic [2:0] o_state, // Init state
    output logic [2:0] o_mr_count, // Mode loads seen
    output logic o_geardown, // Gear-down mode bit
    output logic [7:0] o_bank_open, // Open-bank map
    output logic o_auto_pre, // Last access had auto precharge
    output logic [3:0] o_burst_len // Last access burst length
);
    dri_pkg::dri_state_t state;
    logic [dri_pkg::CNT_W-1:0] wait_cnt;
    logic rst_m;
    logic rst_s;
    logic cke_m;
    logic cke_s;
    logic cal_m;
    logic cal_s;
    logic odt_m;
    logic odt_s;
    // Link domain: command capture with toggle handoff
    logic [4:0] l_cmd;
    logic [16:0] l_addr;
    logic [2:0] l_bank;
    logic l_tog;
    logic odt_l;
    logic [2:0] tog_sync;
    logic [4:0] s_cmd;
    logic [16:0] s_addr;
    logic [2:0] s_bank;
    logic cmd_seen;
    logic hold_rst;

    // Either reset restarts the whole sequence
    assign hold_rst = !i_resetn || !rst_s;

    function automatic logic [2:0] bank_idx(input logic [1:0] bg,
                                            input logic [1:0] ba);
        bank_idx = {bg[0], ba};
    endfunction

    // Activate has chip select and activate both low
    function automatic logic is_act(input logic [4:0] cmd);
        is_act = cmd[4:3] == 2'b00;
    endfunction

    function automatic logic is_access(input logic [4:0] cmd);
        is_access = cmd == dri_pkg::CMD_RD || cmd == dri_pkg::CMD_WR;
    endfunction

    // Before CKE is registered the link is refused and unterminated
    function automatic logic pre_cke(input dri_pkg::dri_state_t st);
        pre_cke = st == dri_pkg::ST_RESET || st == dri_pkg::ST_INTERNAL
            || st == dri_pkg::ST_WAIT_CKE;
    endfunction

    // CK may stand still in reset, so the toggle is re-armed by CKE low
    always_ff @(posedge i_clk_link) begin
        if (!i_cke) begin
            l_tog <= 1'b0;
        end else if (i_cmd != dri_pkg::CMD_DES) begin
            l_cmd <= i_cmd;
            l_addr <= i_addr;
            l_bank <= bank_idx(i_bg, i_ba);
            l_tog <= ~l_tog;
        end
    end

    always_ff @(posedge i_clk_link) begin
        odt_l <= i_odt;
    end

    always_ff @(posedge i_clk_sys) begin
        rst_m <= i_dram_reset_n;
        rst_s <= rst_m;
    end

    always_ff @(posedge i_clk_sys) begin
        cke_m <= i_cke;
        cke_s <= cke_m;
    end

    always_ff @(posedge i_clk_sys) begin
        cal_m <= i_cal_done;
        cal_s <= cal_m;
    end

    // ODT crosses from the link clock like any pin
    always_ff @(posedge i_clk_sys) begin
        odt_m <= odt_l;
        odt_s <= odt_m;
    end

    // Held clear with the link toggle so no false command follows reset
    always_ff @(posedge i_clk_sys) begin
        if (hold_rst || pre_cke(state))
            tog_sync <= '0;
        else
            tog_sync <= {tog_sync[1:0], l_tog};
    end

    // Words stable by the time the toggle is seen twice synchronised
    always_ff @(posedge i_clk_sys) begin
        if (hold_rst || pre_cke(state))
            cmd_seen <= 1'b0;
        else
            cmd_seen <= tog_sync[2] ^ tog_sync[1];
        if (tog_sync[2] ^ tog_sync[1]) begin
            s_cmd <= l_cmd;
            s_addr <= l_addr;
            s_bank <= l_bank;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (hold_rst) begin
            state <= dri_pkg::ST_RESET;
            wait_cnt <= '0;
        end else begin
            unique case (state)
                dri_pkg::ST_RESET: begin
                    state <= dri_pkg::ST_INTERNAL;
                    wait_cnt <= '0;
                end
                dri_pkg::ST_INTERNAL: begin
                    // Runs on the system clock, not CK
                    if (wait_cnt == dri_pkg::CNT_W'(dri_pkg::INIT_WAIT_CYC - 1))
                        state <= dri_pkg::ST_WAIT_CKE;
                    else
                        wait_cnt <= wait_cnt + 1'b1;
                end
                dri_pkg::ST_WAIT_CKE:
                    if (cke_s) state <= dri_pkg::ST_MODE_LOAD;
                dri_pkg::ST_MODE_LOAD:
                    if (cmd_seen && s_cmd == dri_pkg::CMD_ZQCL)
                        state <= dri_pkg::ST_CAL;
                // Waits are timed by the controller; only their end is seen
                dri_pkg::ST_CAL:
                    if (cal_s) state <= dri_pkg::ST_READY;
                dri_pkg::ST_READY: state <= dri_pkg::ST_READY;
                default: state <= dri_pkg::ST_RESET;
            endcase
        end
    end

    // Mode register tracking and defaults
    always_ff @(posedge i_clk_sys) begin
        if (hold_rst) begin
            o_geardown <= dri_pkg::GEARDOWN_RST;
            o_mr_count <= '0;
        end else if (cmd_seen && s_cmd == dri_pkg::CMD_MRS) begin
            o_mr_count <= o_mr_count + 1'b1;
            if (s_addr[dri_pkg::MR_SEL_LSB +: 3] == dri_pkg::MR_GEARDOWN)
                o_geardown <= s_addr[dri_pkg::GD_BIT];
        end
    end

    // Bank state and burst decode
    always_ff @(posedge i_clk_sys) begin
        if (hold_rst || state != dri_pkg::ST_READY) begin
            o_bank_open <= '0;
            o_auto_pre <= 1'b0;
            o_burst_len <= 4'(dri_pkg::BURST_LEN_FULL);
        end else if (cmd_seen) begin
            if (is_act(s_cmd))
                o_bank_open[s_bank] <= 1'b1;
            // Access to a closed bank is refused
            else if (is_access(s_cmd) && o_bank_open[s_bank]) begin
                o_auto_pre <= s_addr[dri_pkg::AP_BIT];
                if (s_addr[dri_pkg::AP_BIT])
                    o_bank_open[s_bank] <= 1'b0;
                o_burst_len <= s_addr[dri_pkg::BC_BIT]
                    ? 4'(dri_pkg::BURST_LEN_FULL)
                    : 4'(dri_pkg::BURST_LEN_CHOP);
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_odt_active <= 1'b0;
            o_ready <= 1'b0;
            o_state <= '0;
        end else begin
            // Sampled ODT level is quasi-static during init
            o_odt_active <= rst_s && !pre_cke(state)
                && odt_s;
            o_ready <= state == dri_pkg::ST_READY;
            o_state <= state;
        end
    end
endmodule
`default_nettype wire

// ### bench/dri_init_assertions.sv
// Checker for the init tracker, bound to its top-level ports.
// Assumes the pin reset is held well beyond four system cycles.
`default_nettype none
module dri_init_chk (
    input wire logic i_clk_sys, // System clock
    input wire logic i_resetn, // Sync reset
    input wire logic i_dram_reset_n, // Pin reset
    input wire logic o_odt_active, // Termination on
    input wire logic o_ready, // Ready
    input wire logic [2:0] o_state, // State
    input wire logic [2:0] o_mr_count, // Mode loads
    input wire logic o_geardown, // Gear-down
    input wire logic [7:0] o_bank_open, // Open banks
    input wire logic [3:0] o_burst_len // Burst length
);
    default clocking @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_resetn);
    sequence s_to_ready;
        $rose(o_state == 3'h5);
    endsequence
    property p_odt; !i_dram_reset_n |-> ##4 !o_odt_active; endproperty
    a_odt: assert property (p_odt) else $error("odt on");
    property p_rdy; !i_dram_reset_n |-> ##4 !o_ready; endproperty
    a_rdy: assert property (p_rdy) else $error("ready in reset");
    property p_gd; o_state == 3'h1 |-> !o_geardown; endproperty
    a_gd: assert property (p_gd) else $error("gear-down set");
    property p_hold; $rose(o_state == 3'h1) |-> (o_state == 3'h1)[*8];
    endproperty
    a_hold: assert property (p_hold) else $error("init cut");
    property p_up; s_to_ready |=> o_ready; endproperty
    a_up: assert property (p_up) else $error("no ready");
    property p_cal; s_to_ready |-> $past(o_state) == 3'h4; endproperty
    a_cal: assert property (p_cal) else $error("ready early");
    property p_mr; $rose(o_state == 3'h4) |-> o_mr_count == 3'h7; endproperty
    a_mr: assert property (p_mr) else $error("mode loads");
    property p_bank; $rose(|o_bank_open) |-> o_state == 3'h5; endproperty
    a_bank: assert property (p_bank) else $error("bank early");
    property p_bl; o_burst_len inside {4'h4, 4'h8}; endproperty
    a_bl: assert property (p_bl) else $error("burst length");
endmodule
bind dri_init dri_init_chk u_chk (.*);
`default_nettype wire

// ### bench/dri_ctl_model.sv
// Controller model: pin reset, link clock, CKE, ODT and commands.
// Assumes one bench process calls its tasks.
`default_nettype none
module dri_ctl_model (
    output logic o_clk, // Link clock
    output logic o_rst_n, // Pin reset
    output logic o_cke, // Clock enable
    output logic o_odt, // Termination, held static
    output logic [4:0] o_cmd, // Command
    output logic [20:0] o_a, // Bank group, bank, address
    output logic o_cal // DLL and ZQ waits over
);
    timeunit 1ns;
    timeprecision 1ps;
    logic run = 0;
    initial begin
        // No test enable pin here; it counts as held low
        {o_clk, o_rst_n, o_cke, o_odt, o_cal} = 0;
        {o_cmd, o_a} = {dri_pkg::CMD_DES, 21'h0};
        forever #62.5 o_clk = run & ~o_clk;
    end
    task automatic power_up(input int hold);
        {run, o_cke, o_cal, o_rst_n} = 0;
        // High and static: nominal termination is requested once CKE is seen
        o_odt = 1'b1;
        #(hold) o_rst_n = 1;
        #500_000 run = 1;
        repeat (6) @(posedge o_clk);
        o_cke <= 1;
        repeat (6) @(posedge o_clk);
    endtask
    task automatic issue(input logic [4:0] c, input logic [20:0] a);
        @(posedge o_clk) {o_cmd, o_a} <= {c, a};
        // Released lines show the inverse, never a stale value
        @(posedge o_clk) {o_cmd, o_a} <= {dri_pkg::CMD_DES, ~o_a};
        repeat (2) @(posedge o_clk);
    endtask
    task automatic cal();
        o_cal <= 1;
    endtask
endmodule
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench: power-up, mode loads, access, warm reset.
// Assumes the controller model drives every link-side input.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk_sys = 0, i_resetn = 0, i_clk_link, i_dram_reset_n, i_cke;
    logic i_odt, i_cal_done, o_odt_active, o_ready, o_geardown, o_auto_pre;
    logic [4:0] i_cmd;
    logic [1:0] i_bg, i_ba;
    logic [16:0] i_addr;
    logic [2:0] o_state, o_mr_count;
    logic [7:0] o_bank_open;
    logic [3:0] o_burst_len;
    logic [31:0] r = 32'h0000_1729;
    logic gdv;
    logic [7:0] m_open = 8'h00;
    int m_mr = 0;
    int error_cnt = 0, total_checks = 0, cyc = 0;
    int mr_seq[7] = '{3, 6, 5, 4, 2, 1, 0};
    dri_init DUT (.*);
    dri_ctl_model ctl (.o_clk(i_clk_link), .o_rst_n(i_dram_reset_n),
        .o_cke(i_cke), .o_odt(i_odt), .o_cmd(i_cmd),
        .o_a({i_bg, i_ba, i_addr}), .o_cal(i_cal_done));
    initial forever #10 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) if (++cyc == 80000) begin
        error_cnt++;
        summarize();
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    task automatic chk(input logic [7:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d bad %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge i_clk_sys);
        i_resetn = 1;
        fork
            ctl.power_up(200_000);
            begin
                #190_000 chk(o_odt_active, 0);
                #500_000 chk(o_state, 1);
                chk(o_odt_active, 0);
            end
        join
        @(negedge i_clk_sys);
        chk(o_state, 3);
        chk(o_odt_active, 1);
        chk(o_geardown, 0);
        // Loaded high so the load stands out against the reset default
        gdv = 1'b1;
        foreach (mr_seq[k]) begin
            ctl.issue(dri_pkg::CMD_MRS, {4'h0, mr_seq[k][2:0], 10'h0,
                gdv & (mr_seq[k] == 3), 3'h0});
            m_mr++;
        end
        @(negedge i_clk_sys);
        chk(o_mr_count, m_mr);
        chk(o_geardown, gdv);
        ctl.issue(dri_pkg::CMD_ZQCL, 21'h0);
        @(negedge i_clk_sys);
        chk(o_state, 4);
        chk(o_ready, 0);
        ctl.cal();
        repeat (10) @(negedge i_clk_sys);
        chk(o_ready, 1);
        chk(o_state, 5);
        $display("power-up test done");
        for (int n = 0; n < 6; n++) begin
            r = xs(r);
            ctl.issue(5'h0, {r[3:0], 2'h0, r[18:4]});
            m_open[r[2:0]] = 1'b1;
            @(negedge i_clk_sys);
            chk(o_bank_open, m_open);
            ctl.issue(r[20] ? dri_pkg::CMD_RD : dri_pkg::CMD_WR,
                {r[3:0], 4'h0, r[12], 1'h0, r[10], r[9:0]});
            if (r[10]) m_open[r[2:0]] = 1'b0;
            @(negedge i_clk_sys);
            chk(o_burst_len, r[12] ? 8 : 4);
            chk(o_auto_pre, r[10]);
            chk(o_bank_open, m_open);
        end
        // Auto precharge closes bank 0; the next read must be refused
        ctl.issue(5'h0, 21'h0);
        ctl.issue(dri_pkg::CMD_RD, 21'h0_1400);
        ctl.issue(dri_pkg::CMD_RD, 21'h0);
        m_open[0] = 1'b0;
        @(negedge i_clk_sys);
        chk(o_auto_pre, 1);
        chk(o_burst_len, 8);
        chk(o_bank_open, m_open);
        $display("access test done");
        fork
            ctl.power_up(100);
            begin
                #400 @(negedge i_clk_sys);
                chk(o_ready, 0);
                chk(o_state, 1);
                chk(o_bank_open, 0);
                chk(o_mr_count, 0);
            end
        join
        @(negedge i_clk_sys);
        chk(o_state, 3);
        chk(o_geardown, 0);
        $display("warm reset test done");
        summarize();
    end
endmodule
`default_nettype wire
